// file: design/ookm_mode_ctrl.sv
`timescale 1ns/100ps
// Operation
// - direction hold 1667 us with both rate selects low, 417 us with one high; 137 us limit with both high is unused, standby holds direction low
// - direction output changes at least 270 ns before the receive output; in standby the receive output follows carrier with direction low
// - both rate selects high selects standby
// - standby keeps the receive path detecting carrier and driving output
// - standby keeps the coax output quiet regardless of transmit data
// - outside standby start in idle; receive output high, coax quiet
// - idle with no carrier past time-out: receive high, direction low
// - idle moves to receive when valid carrier is detected
// - idle moves to transmit when transmit data falls low
// - receive and transmit exclude each other until idle returns
// - in receive, output follows every valid burst from any source
// - output goes low only after carrier persists past noise filter
// - direction stays high through one bits until time-out after activity
// - receive ends 16 bit times after last valid rising edge of output
// - outside standby carrier is sent while transmit data is low
// - transmit mode holds the receive output high, coax input ignored
// - transmit mode holds direction low for message and its time-out
// - transmit ends 16 bit times after transmit data last rises
// - carrier is the reference clock divided by four
// - noise filter 4 us at slowest rate, 2 us at faster rates
module ookm_mode_ctrl
  import ookm_pkg::*;
#(
  parameter int unsigned DIR_SLOW = DIR_SLOW_REF,
  parameter int unsigned DIR_MID = DIR_MID_REF,
  parameter int unsigned DIR_FAST = DIR_FAST_REF,
  parameter int unsigned NOISE_SLOW = NOISE_SLOW_CYC,
  parameter int unsigned NOISE_FAST = NOISE_FAST_CYC,
  parameter int unsigned LEAD = DIR_LEAD_CYC
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_arst_n,
  // rate selects, low when open
  input wire logic i_rate_select_a,
  input wire logic i_rate_select_b,
  // host side
  input wire logic i_mod_data_in,
  output logic o_demod_data_out,
  output logic o_dir,
  // coax side: carrier detected level and carrier out
  input wire logic i_coax_rx_in,
  output logic o_coax_tx_out,
  // mode view
  output logic [1:0] o_mode
);
  localparam int unsigned TW = 16;
  localparam int unsigned NW = 10;
  localparam int unsigned LW = 6;

  logic ref_tick;
  ookm_mode_t mode_r;
  ookm_mode_t mode_nxt;
  logic stby;
  logic slow;
  logic [TW-1:0] tmo_lim;
  logic [NW-1:0] nf_lim;
  logic [TW-1:0] tmo_r;
  logic [NW-1:0] nf_r;
  logic carrier_q_r;
  logic carrier_q_d_r;
  logic tx_d_r;
  logic activity;
  logic expired;
  logic [1:0] car_ph_r;
  logic [LW-1:0] dly_r;
  logic [LW-1:0] lead_lim;
  logic demod_pend_r;
  logic demod_tgt_r;

  // standby and rate decode; open pins read as low
  assign stby = i_rate_select_a & i_rate_select_b;
  assign slow = ~i_rate_select_a & ~i_rate_select_b;
  assign lead_lim = LW'(LEAD);

  // time-out and noise filter limits from rate selects
  always_comb
  begin
    if (slow)
    begin
      tmo_lim = TW'(DIR_SLOW);
      nf_lim = NW'(NOISE_SLOW);
    end
    else if (i_rate_select_a && i_rate_select_b)
    begin
      tmo_lim = TW'(DIR_FAST);
      nf_lim = NW'(NOISE_FAST);
    end
    else if (i_rate_select_a)
    begin
      tmo_lim = TW'(DIR_MID);
      nf_lim = NW'(NOISE_FAST);
    end
    else
    begin
      tmo_lim = TW'(DIR_MID);
      nf_lim = NW'(NOISE_FAST);
    end
  end

  // reference tick generator at 8.704 MHz
  ookm_ref_div #(
    .IN_HZ(CLK_HZ),
    .OUT_HZ(REF_HZ)
  ) u_ref_div (
    .i_clk(i_clk),
    .i_arst_n(i_arst_n),
    .o_tick(ref_tick)
  );

  // noise filter: carrier qualified after persisting past filter time
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      nf_r <= '0;
      carrier_q_r <= 1'b0;
    end
    else if (!i_coax_rx_in)
    begin
      nf_r <= '0;
      carrier_q_r <= 1'b0;
    end
    else if (nf_r >= nf_lim)
    begin
      carrier_q_r <= 1'b1;
    end
    else
    begin
      nf_r <= nf_r + NW'(1);
    end
  end

  // edge history of qualified carrier and transmit data
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      carrier_q_d_r <= 1'b0;
      tx_d_r <= 1'b1;
    end
    else
    begin
      carrier_q_d_r <= carrier_q_r;
      tx_d_r <= i_mod_data_in;
    end
  end

  // activity restarting the time-out, per mode
  always_comb
  begin
    activity = 1'b0;
    unique case (mode_r)
      OOKM_RX: activity = carrier_q_r;
      OOKM_TX: activity = ~i_mod_data_in;
      OOKM_IDLE: activity = 1'b0;
      OOKM_STBY: activity = 1'b0;
    endcase
  end

  assign expired = (tmo_r >= tmo_lim);

  // time-out counter on reference ticks
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      tmo_r <= '0;
    end
    else if (activity || mode_r == OOKM_IDLE || mode_r == OOKM_STBY)
    begin
      tmo_r <= '0;
    end
    else if (ref_tick && !expired)
    begin
      tmo_r <= tmo_r + TW'(1);
    end
  end

  // mode next state
  always_comb
  begin
    mode_nxt = mode_r;
    if (stby)
    begin
      mode_nxt = OOKM_STBY;
    end
    else
    begin
      unique case (mode_r)
        OOKM_STBY: mode_nxt = OOKM_IDLE;
        OOKM_IDLE:
          if (carrier_q_r)
            mode_nxt = OOKM_RX;
          else if (!i_mod_data_in && tx_d_r)
            mode_nxt = OOKM_TX;
        OOKM_RX:
          if (expired && !carrier_q_r)
            mode_nxt = OOKM_IDLE;
        OOKM_TX:
          if (expired && i_mod_data_in)
            mode_nxt = OOKM_IDLE;
      endcase
    end
  end

  // mode register, idle from power-on
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      mode_r <= OOKM_IDLE;
    else
      mode_r <= mode_nxt;
  end

  // direction output, high only in receive
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      o_dir <= 1'b0;
    else
      o_dir <= (mode_nxt == OOKM_RX);
  end

  // demodulated output target and delay behind direction
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      demod_tgt_r <= 1'b1;
      demod_pend_r <= 1'b0;
      dly_r <= '0;
      o_demod_data_out <= 1'b1;
    end
    else
    begin
      // receive or standby follow qualified carrier, else high
      if (mode_nxt == OOKM_RX || mode_nxt == OOKM_STBY)
        demod_tgt_r <= ~carrier_q_r;
      else
        demod_tgt_r <= 1'b1;
      if (demod_tgt_r != o_demod_data_out && !demod_pend_r)
      begin
        demod_pend_r <= 1'b1;
        dly_r <= '0;
      end
      else if (demod_pend_r)
      begin
        if (dly_r >= lead_lim)
        begin
          o_demod_data_out <= demod_tgt_r;
          demod_pend_r <= 1'b0;
        end
        else
        begin
          dly_r <= dly_r + LW'(1);
        end
      end
    end
  end

  // carrier phase: reference divided by four
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      car_ph_r <= 2'h0;
    else if (ref_tick)
      car_ph_r <= car_ph_r + 2'h1;
  end

  // coax output, quiet in standby or with data high
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      o_coax_tx_out <= 1'b0;
    else if (stby || i_mod_data_in)
      o_coax_tx_out <= 1'b0;
    else
      o_coax_tx_out <= car_ph_r[1];
  end

  // mode view
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      o_mode <= 2'h0;
    else
      o_mode <= mode_nxt;
  end
endmodule : ookm_mode_ctrl

// file: design/ookm_pkg.sv
package ookm_pkg;
  // system clock rate
  localparam int unsigned CLK_HZ = 125000000;
  localparam int unsigned CLK_NS_X10 = 80; // period in 0.1 ns
  // reference oscillator and carrier
  localparam int unsigned REF_HZ = 8704000;
  localparam int unsigned REF_PER_CARRIER = 4;
  // direction hold times in microseconds
  localparam int unsigned DIR_HOLD_SLOW_US = 1667;
  localparam int unsigned DIR_HOLD_MID_US = 417;
  localparam int unsigned DIR_HOLD_FAST_US = 137;
  // noise filter times in microseconds
  localparam int unsigned NOISE_SLOW_US = 4;
  localparam int unsigned NOISE_FAST_US = 2;
  // direction lead time in nanoseconds
  localparam int unsigned DIR_LEAD_NS = 270;
  // time-out counts in reference clock ticks (longest time, round down)
  localparam int unsigned DIR_SLOW_REF = (DIR_HOLD_SLOW_US * 8704) / 1000;
  localparam int unsigned DIR_MID_REF = (DIR_HOLD_MID_US * 8704) / 1000;
  localparam int unsigned DIR_FAST_REF = (DIR_HOLD_FAST_US * 8704) / 1000;
  // noise filter in system clocks (least time, round up)
  localparam int unsigned NOISE_SLOW_CYC =
    (NOISE_SLOW_US * 1000 * 10 + CLK_NS_X10 - 1) / CLK_NS_X10;
  localparam int unsigned NOISE_FAST_CYC =
    (NOISE_FAST_US * 1000 * 10 + CLK_NS_X10 - 1) / CLK_NS_X10;
  // direction lead in system clocks (least time, round up)
  localparam int unsigned DIR_LEAD_CYC =
    (DIR_LEAD_NS * 10 + CLK_NS_X10 - 1) / CLK_NS_X10;
  // operating modes
  typedef enum logic [1:0]
  {
    OOKM_IDLE = 2'b00,
    OOKM_RX = 2'b01,
    OOKM_TX = 2'b10,
    OOKM_STBY = 2'b11
  } ookm_mode_t;
endpackage : ookm_pkg

// file: design/ookm_ref_div.sv
`timescale 1ns/100ps
// fractional divider: one-cycle pulse at an average rate of out_hz
module ookm_ref_div #(
  parameter int unsigned IN_HZ = 125000000,
  parameter int unsigned OUT_HZ = 8704000
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_arst_n,
  // tick out
  output logic o_tick
);
  logic [31:0] acc_r;
  logic [32:0] sum;

  // phase accumulator with wrap at in_hz
  always_comb
  begin
    sum = {1'b0, acc_r} + 33'(OUT_HZ);
  end

  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      acc_r <= 32'h0;
      o_tick <= 1'b0;
    end
    else if (sum >= 33'(IN_HZ))
    begin
      acc_r <= 32'(sum - 33'(IN_HZ));
      o_tick <= 1'b1;
    end
    else
    begin
      acc_r <= sum[31:0];
      o_tick <= 1'b0;
    end
  end
endmodule : ookm_ref_div

// file: dv/ookm_remote_model.sv
`timescale 1ns/100ps
// remote modem: carrier detect high for one burst of len cycles
module ookm_remote (
  // clock and burst request
  input wire logic i_clk,
  input wire logic i_go,
  input wire logic [11:0] i_len,
  // carrier detect towards the device
  output logic o_carrier
);
  logic [11:0] left_r = 12'h000;
  // burst counter; the line drops low between bursts
  always_ff @(posedge i_clk)
  begin
    if (i_go)
      left_r <= i_len;
    else if (left_r != 12'h000)
      left_r <= left_r - 12'h001;
  end
  assign o_carrier = (left_r != 12'h000);
endmodule : ookm_remote

// file: dv/ookm_mode_ctrl_assertions.sv
`timescale 1ns/100ps
// checks mode, direction and carrier relations at the ports
module ookm_mode_ctrl_chk (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_arst_n,
  // inputs
  input wire logic i_rate_select_a,
  input wire logic i_rate_select_b,
  input wire logic i_mod_data_in,
  // outputs
  input wire logic o_demod_data_out,
  input wire logic o_dir,
  input wire logic o_coax_tx_out,
  input wire logic [1:0] o_mode
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_arst_n);
  // inputs held steady for a few cycles
  sequence s_stby;
    (i_rate_select_a && i_rate_select_b) [*4];
  endsequence
  sequence s_tx_high;
    i_mod_data_in [*3];
  endsequence
  // mode relations
  property p_stby;
    s_stby |-> o_mode == 2'h3;
  endproperty
  property p_stby_q;
    o_mode == 2'h3 && $past(o_mode) == 2'h3 |-> !o_coax_tx_out;
  endproperty
  property p_idle;
    o_mode == 2'h0 && $past(o_mode) == 2'h0 |-> o_demod_data_out && !o_dir;
  endproperty
  property p_mod_data_in;
    $fell(i_mod_data_in) && o_mode == 2'h0 |-> ##[1:2] o_mode == 2'h2;
  endproperty
  property p_excl;
    o_mode == 2'h1 || o_mode == 2'h2 |=> o_mode != ~$past(o_mode);
  endproperty
  property p_lead;
    $fell(o_demod_data_out) && o_mode == 2'h1 |-> $past(o_dir, 34);
  endproperty
  property p_tx_rx;
    o_mode == 2'h2 |-> o_demod_data_out;
  endproperty
  property p_tx_dir;
    o_mode == 2'h2 |-> !o_dir;
  endproperty
  property p_quiet;
    s_tx_high |-> !o_coax_tx_out;
  endproperty
  a_stby: assert property (p_stby) else $error("no standby");
  a_stby_q: assert property (p_stby_q) else $error("tx on");
  a_idle: assert property (p_idle) else $error("idle out");
  a_mod_data_in: assert property (p_mod_data_in) else $error("no tx");
  a_excl: assert property (p_excl) else $error("rx tx swap");
  a_lead: assert property (p_lead) else $error("dir late");
  a_tx_rx: assert property (p_tx_rx) else $error("tx demod");
  a_tx_dir: assert property (p_tx_dir) else $error("tx dir");
  a_quiet: assert property (p_quiet) else $error("not quiet");
endmodule : ookm_mode_ctrl_chk

bind ookm_mode_ctrl ookm_mode_ctrl_chk i_chk (.i_clk, .i_arst_n,
  .i_rate_select_a, .i_rate_select_b, .i_mod_data_in, .o_demod_data_out,
  .o_dir, .o_coax_tx_out, .o_mode);

// file: dv/testbench.sv
`timescale 1ns/100ps
module testbench;
  // stimulus and observed signals
  logic i_clk = 1'b0;
  logic i_arst_n = 1'b0;
  logic i_rate_select_a = 1'b0;
  logic i_rate_select_b = 1'b0;
  logic i_mod_data_in = 1'b1; // host idles high
  logic go = 1'b0;
  logic [11:0] len = 12'h000;
  logic i_coax_rx_in;
  logic o_demod_data_out;
  logic o_dir;
  logic o_coax_tx_out;
  logic [1:0] o_mode;
  logic idle;
  int errors = 0;
  int check_count = 0;
  int rises = 0;
  int n;
  // 8 ns clock, idle flag and carrier pulse count
  always #4 i_clk = ~i_clk;
  always_comb idle = (o_mode === 2'h0);
  always @(posedge o_coax_tx_out) rises++;
  // remote modem and device
  ookm_remote i_ookm_remote (.i_clk, .i_go(go), .i_len(len),
    .o_carrier(i_coax_rx_in));
  ookm_mode_ctrl #(.DIR_SLOW(40), .DIR_MID(20), .DIR_FAST(10),
    .NOISE_SLOW(8), .NOISE_FAST(4)) i_ookm_mode_ctrl (.i_clk, .i_arst_n,
    .i_rate_select_a, .i_rate_select_b, .i_mod_data_in, .o_demod_data_out,
    .o_dir, .i_coax_rx_in, .o_coax_tx_out, .o_mode);
  task automatic chk(input string what, input logic [11:0] e,
    input logic [11:0] g);
    if (g !== e)
    begin
      $display("Error %s expected %0h seen %0h", what, e, g);
      errors++;
    end
    check_count++;
  endtask : chk
  task automatic rng(input string what, input int lo, input int hi,
    input int g);
    chk(what, 1'b1, g >= lo && g <= hi);
  endtask : rng
  task automatic step(input int k);
    repeat (k) @(posedge i_clk);
    #1;
  endtask : step
  task automatic burst(input int k);
    len = k[11:0];
    go = 1'b1;
    step(1);
    go = 1'b0;
  endtask : burst
  task automatic wait_lvl(ref logic s, input logic v);
    n = 0;
    while (s !== v && n < 3000)
    begin
      step(1);
      n++;
    end
    rng("wait", 0, 2999, n);
  endtask : wait_lvl
  task automatic test_done();
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : test_done
  task automatic t_noise();
    burst(8);
    step(60);
    chk("slow burst", 0, o_mode);
    chk("slow demod", 1, o_demod_data_out);
    i_rate_select_a = 1'b1;
    burst(8);
    step(12);
    chk("fast burst", 1, o_mode);
    chk("rx dir", 1, o_dir);
    wait_lvl(idle, 1'b1);
    chk("idle dir", 0, o_dir);
  endtask : t_noise
  task automatic t_rx();
    burst(200);
    wait_lvl(o_dir, 1'b1);
    wait_lvl(o_demod_data_out, 1'b0);
    rng("lead", 34, 99, n);
    i_mod_data_in = 1'b0;
    rises = 0;
    step(80);
    chk("rx excl", 1, o_mode);
    rng("rx carrier out", 1, 9, rises);
    i_mod_data_in = 1'b1;
    wait_lvl(o_demod_data_out, 1'b1);
    chk("one bit dir", 1, o_dir);
    burst(50);
    step(50);
    chk("second burst", 0, o_demod_data_out);
    wait_lvl(idle, 1'b1);
    rng("rx hold", 260, 320, n);
  endtask : t_rx
  task automatic t_tx(input logic a, input logic b, input int ticks);
    int e;
    e = ticks * 125000 / 8704;
    i_rate_select_a = a;
    i_rate_select_b = b;
    step(2);
    i_mod_data_in = 1'b0;
    rises = 0;
    step(3);
    chk("tx mode", 2, o_mode);
    burst(100);
    step(150);
    chk("tx demod", 1, o_demod_data_out);
    chk("tx dir", 0, o_dir);
    rng("tx carrier", 1, 9, rises);
    i_mod_data_in = 1'b1;
    step(3);
    chk("tx quiet", 0, o_coax_tx_out);
    wait_lvl(idle, 1'b1);
    rng("tx hold", e - 30, e + 30, n);
  endtask : t_tx
  task automatic t_stby();
    i_rate_select_a = 1'b1;
    i_rate_select_b = 1'b1;
    step(4);
    chk("standby", 3, o_mode);
    i_mod_data_in = 1'b0;
    rises = 0;
    burst(100);
    step(80);
    chk("stby demod", 0, o_demod_data_out);
    rng("stby tx", 0, 0, rises);
    i_mod_data_in = 1'b1;
  endtask : t_stby
  // main sequence
  initial
  begin
    step(16);
    i_arst_n = 1'b1;
    step(1);
    chk("demod", 1, o_demod_data_out);
    chk("mode", 0, o_mode);
    t_noise();
    t_rx();
    t_tx(1'b0, 1'b0, 40);
    t_tx(1'b1, 1'b0, 20);
    t_tx(1'b0, 1'b1, 20);
    t_stby();
    test_done();
  end
  // watchdog
  initial
  begin
    #200000;
    errors++;
    test_done();
  end
endmodule : testbench
